// [common/ahl_params.svh]
// constants of the ascii host-link command framer
`ifndef AHL_PARAMS_SVH
`define AHL_PARAMS_SVH
`define AHL_HDR_PCT 8'h25
`define AHL_HDR_LT 8'h3c
`define AHL_CHR_CR 8'h0d
`define AHL_CHR_STAR 8'h2a
`define AHL_CHR_OK 8'h24
`define AHL_CHR_ERR 8'h21
`define AHL_ASCII_ZERO 8'h30
`define AHL_ASCII_HEXA 8'h37
`define AHL_MAX_PCT 12'd118
`define AHL_MAX_LT 12'd2048
`define AHL_TAIL_CHARS 12'd3
`define AHL_RSP_FIRST_POS 12'd5
`define AHL_UNIT_MIN 7'd1
`define AHL_UNIT_MAX 7'd99
`define AHL_CLK_MHZ 25
`define AHL_RSP_TIMEOUT_MS 1000
`define AHL_RSP_TIMEOUT_CYC (`AHL_RSP_TIMEOUT_MS * 1000 * `AHL_CLK_MHZ)
`define AHL_FIFO_DEPTH 8
`endif

// [common/ahl_pkg.sv]
// types of the ascii host-link command framer
package ahl_pkg;
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } ahl_byte_t;
   typedef struct packed {
      logic hdrLt;
      logic skipBcc;
      logic [6:0] unit;
   } ahl_cmd_t;
   typedef struct packed {
      logic ok;
      logic remoteErr;
      logic bccErr;
      logic unitErr;
      logic lenErr;
      logic cfgErr;
      logic timeout;
   } ahl_result_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_TX_HDR = 4'h1,
      ST_TX_U1 = 4'h2,
      ST_TX_U0 = 4'h3,
      ST_TX_TXT = 4'h4,
      ST_DRAIN = 4'h5,
      ST_TX_B1 = 4'h6,
      ST_TX_B0 = 4'h7,
      ST_TX_CR = 4'h8,
      ST_RX_HDR = 4'h9,
      ST_RX_U1 = 4'ha,
      ST_RX_U0 = 4'hb,
      ST_RX_BODY = 4'hc
   } ahl_state_t;
endpackage

// [rtl/ahl_fifo.sv]
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module ahl_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [W-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam logic [AW:0] FULL = (AW + 1)'(D);
   localparam logic [AW-1:0] LASTP = AW'(D - 1);
   logic [W-1:0] mem_r [D];
   logic [W-1:0] mem_nxt [D];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   assign inReady = (cnt_r != FULL);
   assign outValid = (cnt_r != '0);
   assign outData = mem_r[rp_r];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      mem_nxt = mem_r;
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      if (push) begin
         mem_nxt[wp_r] = inData;
         wp_nxt = (wp_r == LASTP) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
         rp_nxt = (rp_r == LASTP) ? '0 : rp_r + AW'(1);
      end
      if (push && !pop) begin
         cnt_nxt = cnt_r + (AW + 1)'(1);
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - (AW + 1)'(1);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < D; i++) begin
            mem_r[i] <= '0;
         end
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         mem_r <= mem_nxt;
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
endmodule

// [rtl/ahl_master.sv]
// master-side command framer and response parser for the ascii host link
//
// Functional notes
// - commands start with percent or less-than header, chosen per command.
// - two ascii unit digits follow the header; unit one gives "01".
// - text is supplied upper case by the user; passed through unchanged.
// - every character on the link is an ascii code.
// - check code is xor of header through last text character.
// - every command ends with carriage return.
// - percent frames at most 118 chars, less-than frames at most 2048.
// - long data spans several commands; user splits it into frames.
// - host sends first, then waits for the response before next command.
// - this block is master; the device is slave.
`timescale 1ns/1ps
`include "ahl_params.svh"
module ahl_master #(
   parameter int unsigned RSP_TIMEOUT = `AHL_RSP_TIMEOUT_CYC,
   parameter int FIFO_DEPTH = `AHL_FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cmdStart,
   input wire ahl_pkg::ahl_cmd_t cmdCfg,
   output logic cmdReady,
   input wire ahl_pkg::ahl_byte_t txtIn,
   input wire logic txtValid,
   output logic txtReady,
   output logic [7:0] txData,
   output logic txValid,
   input wire logic txReady,
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   output logic [7:0] rspData,
   output logic rspValid,
   output logic done,
   output ahl_pkg::ahl_result_t result
);
   ahl_pkg::ahl_state_t state_r, state_nxt, after;
   ahl_pkg::ahl_cmd_t cfg_r, cfg_nxt;
   ahl_pkg::ahl_result_t res_r, res_nxt;
   ahl_pkg::ahl_byte_t fifoOut;
   logic fifoValid, fifoPop;
   logic [7:0] txData_r, txData_nxt, rspData_r, rspData_nxt;
   logic txValid_r, txValid_nxt, txLast_r, txLast_nxt;
   logic rspValid_r, rspValid_nxt, done_r, done_nxt;
   logic [7:0] bcc_r, bcc_nxt, hold0_r, hold0_nxt, hold1_r, hold1_nxt;
   logic [1:0] holdN_r, holdN_nxt;
   logic [11:0] cnt_r, cnt_nxt, lim;
   logic [31:0] tmo_r, tmo_nxt;
   logic load, addBcc, isTx;
   logic [7:0] loadByte, hdrChr;
   logic [15:0] unitAsc, bccAsc;

   function automatic logic [7:0] hexChr(input logic [3:0] n);
      if (n < 4'ha) begin
         return `AHL_ASCII_ZERO + {4'h0, n};
      end
      return `AHL_ASCII_HEXA + {4'h0, n};
   endfunction

   function automatic logic [15:0] unitChars(input logic [6:0] u);
      logic [3:0] tens;
      logic [6:0] rest;
      tens = 4'h0;
      rest = u;
      for (int t = 1; t < 10; t++) begin
         if (rest >= 7'd10) begin
            tens = tens + 4'h1;
            rest = rest - 7'd10;
         end
      end
      return {`AHL_ASCII_ZERO + {4'h0, tens}, `AHL_ASCII_ZERO + {1'b0, rest}};
   endfunction

   // text waits here; a stalled uart backs up into txtReady
   ahl_fifo #(.W(9), .D(FIFO_DEPTH)) txtFifo (
      .core_clk(core_clk),
      .rst(rst),
      .inData(txtIn),
      .inValid(txtValid),
      .inReady(txtReady),
      .outData(fifoOut),
      .outValid(fifoValid),
      .outReady(fifoPop)
   );

   assign hdrChr = cfg_r.hdrLt ? `AHL_HDR_LT : `AHL_HDR_PCT;
   assign unitAsc = unitChars(cfg_r.unit);
   assign bccAsc = {hexChr(bcc_r[7:4]), hexChr(bcc_r[3:0])};
   assign lim = cfg_r.hdrLt ? `AHL_MAX_LT : `AHL_MAX_PCT;
   assign isTx = (state_r inside {ahl_pkg::ST_TX_HDR, ahl_pkg::ST_TX_U1,
      ahl_pkg::ST_TX_U0, ahl_pkg::ST_TX_TXT, ahl_pkg::ST_TX_B1,
      ahl_pkg::ST_TX_B0, ahl_pkg::ST_TX_CR});
   assign cmdReady = (state_r == ahl_pkg::ST_IDLE);
   assign txData = txData_r;
   assign txValid = txValid_r;
   assign rspData = rspData_r;
   assign rspValid = rspValid_r;
   assign done = done_r;
   assign result = res_r;

   always_comb begin
      state_nxt = state_r;
      cfg_nxt = cfg_r;
      res_nxt = res_r;
      txData_nxt = txData_r;
      txValid_nxt = txValid_r;
      txLast_nxt = txLast_r;
      rspData_nxt = rspData_r;
      rspValid_nxt = 1'b0;
      done_nxt = 1'b0;
      bcc_nxt = bcc_r;
      hold0_nxt = hold0_r;
      hold1_nxt = hold1_r;
      holdN_nxt = holdN_r;
      cnt_nxt = cnt_r;
      tmo_nxt = tmo_r;
      fifoPop = 1'b0;
      load = 1'b0;
      addBcc = 1'b1;
      loadByte = 8'h00;
      after = state_r;
      unique case (state_r)
         ahl_pkg::ST_IDLE: begin
            if (cmdStart) begin
               cfg_nxt = cmdCfg;
               res_nxt = '0;
               cnt_nxt = 12'd0;
               bcc_nxt = 8'h00;
               if (cmdCfg.unit < `AHL_UNIT_MIN ||
                   cmdCfg.unit > `AHL_UNIT_MAX) begin
                  res_nxt.cfgErr = 1'b1;
                  done_nxt = 1'b1;
               end else begin
                  state_nxt = ahl_pkg::ST_TX_HDR;
               end
            end
         end
         ahl_pkg::ST_TX_HDR: begin
            load = 1'b1;
            loadByte = hdrChr;
            after = ahl_pkg::ST_TX_U1;
         end
         ahl_pkg::ST_TX_U1: begin
            load = 1'b1;
            loadByte = unitAsc[15:8];
            after = ahl_pkg::ST_TX_U0;
         end
         ahl_pkg::ST_TX_U0: begin
            load = 1'b1;
            loadByte = unitAsc[7:0];
            after = ahl_pkg::ST_TX_TXT;
         end
         ahl_pkg::ST_TX_TXT: begin
            after = txLast_r ? ahl_pkg::ST_TX_B1 : ahl_pkg::ST_TX_TXT;
            if (!txValid_r && fifoValid) begin
               // no room left for check code and terminator
               if (cnt_r >= lim - `AHL_TAIL_CHARS) begin
                  res_nxt.lenErr = 1'b1;
                  state_nxt = ahl_pkg::ST_DRAIN;
               end else begin
                  load = 1'b1;
                  loadByte = fifoOut.data;
                  fifoPop = 1'b1;
                  txLast_nxt = fifoOut.last;
               end
            end
         end
         ahl_pkg::ST_DRAIN: begin
            fifoPop = fifoValid;
            if (fifoValid && fifoOut.last) begin
               state_nxt = ahl_pkg::ST_TX_B1;
            end
         end
         ahl_pkg::ST_TX_B1: begin
            load = 1'b1;
            addBcc = 1'b0;
            loadByte = cfg_r.skipBcc ? `AHL_CHR_STAR : bccAsc[15:8];
            after = ahl_pkg::ST_TX_B0;
         end
         ahl_pkg::ST_TX_B0: begin
            load = 1'b1;
            addBcc = 1'b0;
            loadByte = cfg_r.skipBcc ? `AHL_CHR_STAR : bccAsc[7:0];
            after = ahl_pkg::ST_TX_CR;
         end
         ahl_pkg::ST_TX_CR: begin
            load = 1'b1;
            addBcc = 1'b0;
            loadByte = `AHL_CHR_CR;
            after = ahl_pkg::ST_RX_HDR;
            tmo_nxt = 32'd0;
         end
         ahl_pkg::ST_RX_HDR: begin
            // stray bytes before the right header are dropped
            if (rxValid && rxData == hdrChr) begin
               bcc_nxt = rxData;
               cnt_nxt = 12'd1;
               state_nxt = ahl_pkg::ST_RX_U1;
            end
         end
         ahl_pkg::ST_RX_U1, ahl_pkg::ST_RX_U0: begin
            if (rxValid) begin
               if (rxData != ((state_r == ahl_pkg::ST_RX_U1) ?
                   unitAsc[15:8] : unitAsc[7:0])) begin
                  res_nxt.unitErr = 1'b1;
               end
               bcc_nxt = bcc_r ^ rxData;
               cnt_nxt = cnt_r + 12'd1;
               holdN_nxt = 2'd0;
               state_nxt = (state_r == ahl_pkg::ST_RX_U1) ?
                  ahl_pkg::ST_RX_U0 : ahl_pkg::ST_RX_BODY;
            end
         end
         ahl_pkg::ST_RX_BODY: begin
            if (rxValid && rxData == `AHL_CHR_CR) begin
               // last two held characters are the check code
               if (holdN_r != 2'd2) begin
                  res_nxt.bccErr = 1'b1;
               end else if (!(hold1_r == `AHL_CHR_STAR &&
                  hold0_r == `AHL_CHR_STAR) &&
                  {hold1_r, hold0_r} != bccAsc) begin
                  res_nxt.bccErr = 1'b1;
               end
               state_nxt = ahl_pkg::ST_IDLE;
            end else if (rxValid) begin
               if (holdN_r == 2'd2) begin
                  rspData_nxt = hold1_r;
                  rspValid_nxt = 1'b1;
                  bcc_nxt = bcc_r ^ hold1_r;
                  if (cnt_r == `AHL_RSP_FIRST_POS &&
                      hold1_r == `AHL_CHR_ERR) begin
                     res_nxt.remoteErr = 1'b1;
                  end
               end else begin
                  holdN_nxt = holdN_r + 2'd1;
               end
               hold1_nxt = hold0_r;
               hold0_nxt = rxData;
               cnt_nxt = cnt_r + 12'd1;
               if (cnt_r >= lim - 12'd1) begin
                  res_nxt.lenErr = 1'b1;
               end
            end
         end
         default: begin
            state_nxt = ahl_pkg::ST_IDLE;
         end
      endcase
      // one byte in flight to the uart at a time
      if (isTx) begin
         if (txValid_r) begin
            if (txReady) begin
               txValid_nxt = 1'b0;
               state_nxt = after;
            end
         end else if (load) begin
            txData_nxt = loadByte;
            txValid_nxt = 1'b1;
            cnt_nxt = cnt_r + 12'd1;
            if (addBcc) begin
               bcc_nxt = bcc_r ^ loadByte;
            end
         end
      end
      if (state_r inside {ahl_pkg::ST_RX_HDR, ahl_pkg::ST_RX_U1,
          ahl_pkg::ST_RX_U0, ahl_pkg::ST_RX_BODY}) begin
         // covers the device hold-back of up to 999 scans
         tmo_nxt = tmo_r + 32'd1;
         if (tmo_r >= RSP_TIMEOUT - 32'd1) begin
            res_nxt.timeout = 1'b1;
            state_nxt = ahl_pkg::ST_IDLE;
         end
         if (state_nxt == ahl_pkg::ST_IDLE) begin
            done_nxt = 1'b1;
            res_nxt.ok = !(res_nxt.remoteErr || res_nxt.bccErr ||
               res_nxt.unitErr || res_nxt.lenErr || res_nxt.timeout);
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_r <= ahl_pkg::ST_IDLE;
         cfg_r <= '0;
         res_r <= '0;
         txData_r <= 8'h00;
         txValid_r <= 1'b0;
         txLast_r <= 1'b0;
         rspData_r <= 8'h00;
         rspValid_r <= 1'b0;
         done_r <= 1'b0;
         bcc_r <= 8'h00;
         hold0_r <= 8'h00;
         hold1_r <= 8'h00;
         holdN_r <= 2'd0;
         cnt_r <= 12'd0;
         tmo_r <= 32'd0;
      end else begin
         state_r <= state_nxt;
         cfg_r <= cfg_nxt;
         res_r <= res_nxt;
         txData_r <= txData_nxt;
         txValid_r <= txValid_nxt;
         txLast_r <= txLast_nxt;
         rspData_r <= rspData_nxt;
         rspValid_r <= rspValid_nxt;
         done_r <= done_nxt;
         bcc_r <= bcc_nxt;
         hold0_r <= hold0_nxt;
         hold1_r <= hold1_nxt;
         holdN_r <= holdN_nxt;
         cnt_r <= cnt_nxt;
         tmo_r <= tmo_nxt;
      end
   end
endmodule

// [tb/ahl_master_checker.sv]
// assertion checker for the host-link command framer
`timescale 1ns/1ps
module ahl_master_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cmdStart,
   input wire ahl_pkg::ahl_cmd_t cmdCfg,
   input wire logic cmdReady,
   input wire ahl_pkg::ahl_byte_t txtIn,
   input wire logic txtValid,
   input wire logic txtReady,
   input wire logic [7:0] txData,
   input wire logic txValid,
   input wire logic txReady,
   input wire logic [7:0] rxData,
   input wire logic rxValid,
   input wire logic [7:0] rspData,
   input wire logic rspValid,
   input wire logic done,
   input wire ahl_pkg::ahl_result_t result
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic go;
   logic bad;
   assign go = cmdStart && cmdReady;
   assign bad = cmdCfg.unit < 7'd1 || cmdCfg.unit > 7'd99;
   a_unit_refused: assert property (go && bad |=> done && result.cfgErr)
      else $error("bad unit not refused");
   // header byte is loaded one cycle after idle is left
   a_header_first: assert property (go && !bad |=> ##1 txValid &&
      txData == ($past(cmdCfg.hdrLt, 2) ? 8'h3c : 8'h25))
      else $error("header");
   a_tx_held: assert property (txValid && !txReady |=>
      txValid && $stable(txData)) else $error("tx byte not held");
   a_tx_gap: assert property (txValid && txReady |=> !txValid)
      else $error("no idle cycle after byte");
   a_busy_after: assert property (go && !bad |=> !cmdReady)
      else $error("ready while busy");
   // a refused unit number never leaves the idle state
   a_bad_idle: assert property (go && bad |=> cmdReady)
      else $error("busy after refused unit");
   a_idle_quiet: assert property (cmdReady |-> !txValid)
      else $error("tx while idle");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than a cycle");
   a_ok_exact: assert property (done |-> result.ok == !(result.remoteErr
      || result.bccErr || result.unitErr || result.lenErr || result.cfgErr
      || result.timeout)) else $error("ok flag inconsistent");
   a_rsp_cause: assert property (rspValid |-> $past(rxValid))
      else $error("response byte without rx");
   c_ok: cover property (done && result.ok);
   c_tmo: cover property (done && result.timeout);
   c_full: cover property (!txtReady);
   c_remote: cover property (done && result.remoteErr);
endmodule
bind ahl_master ahl_master_checker u_ahl_master_checker (
   .core_clk(core_clk), .rst(rst), .cmdStart(cmdStart), .cmdCfg(cmdCfg),
   .cmdReady(cmdReady), .txtIn(txtIn), .txtValid(txtValid),
   .txtReady(txtReady), .txData(txData), .txValid(txValid),
   .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
   .rspData(rspData), .rspValid(rspValid), .done(done), .result(result));

// [tb/ahl_device_model.sv]
// behavioural slave device answering host-link commands
`timescale 1ns/1ps
module ahl_device_model #(
   parameter int UNIT = 1,
   parameter int SCAN = 20
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] txData,
   input wire logic txValid,
   output logic txReady,
   output logic [7:0] rxData,
   output logic rxValid,
   input wire logic [9:0] delayScans,
   input wire logic failCmd,
   input wire logic badBcc
);
   logic [7:0] fr[$];
   logic [7:0] rs[$];
   integer seed;
   function automatic logic [7:0] hx(input logic [3:0] n);
      return n < 4'ha ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction
   task automatic answer();
      logic [7:0] x;
      int n;
      n = fr.size();
      x = 8'h00;
      for (int i = 0; i < n - 3; i++) x ^= fr[i];
      if (fr[1] != 8'h30 + 8'(UNIT / 10) || fr[2] != 8'h30 + 8'(UNIT % 10))
         return;
      repeat (delayScans * SCAN) @(negedge core_clk);
      rs = {fr[0], 8'h30 + 8'(UNIT / 10), 8'h30 + 8'(UNIT % 10)};
      if (failCmd || (fr[n-3] != 8'h2a &&
         {fr[n-3], fr[n-2]} != {hx(x[7:4]), hx(x[3:0])}))
         rs = {rs, 8'h21, 8'h34, 8'h32};
      else
         rs = {rs, 8'h24, fr[3]};
      x = 8'h00;
      foreach (rs[i]) x ^= rs[i];
      if (badBcc)
         x = ~x;
      rs = {rs, hx(x[7:4]), hx(x[3:0]), 8'h0d};
      foreach (rs[i]) begin
         @(negedge core_clk);
         rxData = rs[i];
         rxValid = 1'b1;
         @(negedge core_clk);
         rxValid = 1'b0;
         rxData = ~rs[i];
      end
   endtask
   // answers only after the whole command, so the link stays half duplex
   initial begin
      seed = 32'hcc721623;
      txReady = 1'b0;
      rxValid = 1'b0;
      rxData = 8'h00;
      forever begin
         @(negedge core_clk);
         txReady = !rst && ($random(seed) & 3) != 0;
         @(posedge core_clk);
         if (!rst && txValid && txReady) begin
            fr.push_back(txData);
            if (txData == 8'h0d) begin
               answer();
               fr.delete();
            end
         end
      end
   end
endmodule

// [tb/tb_ahl_master.sv]
// self-checking bench for the host-link command framer
`timescale 1ns/1ps
module tb_ahl_master;
   logic core_clk, rst, cmdStart, txtValid, txReady, rxValid;
   logic cmdReady, txtReady, txValid, rspValid, done, failCmd, badBcc;
   ahl_pkg::ahl_cmd_t cmdCfg;
   ahl_pkg::ahl_byte_t txtIn;
   ahl_pkg::ahl_result_t result, er;
   logic [7:0] txData, rxData, rspData;
   logic [9:0] delayScans;
   int errors, tests_run, cyc, txtHead, crCyc, doneCyc;
   integer seed;
   ahl_pkg::ahl_byte_t txtArr[$];
   logic [7:0] txQ[$], rspQ[$], expTx[$], expRsp[$];
   ahl_master #(.RSP_TIMEOUT(2000)) u_ahl_master (.core_clk(core_clk),
      .rst(rst), .cmdStart(cmdStart), .cmdCfg(cmdCfg), .cmdReady(cmdReady),
      .txtIn(txtIn), .txtValid(txtValid), .txtReady(txtReady),
      .txData(txData), .txValid(txValid), .txReady(txReady),
      .rxData(rxData), .rxValid(rxValid), .rspData(rspData),
      .rspValid(rspValid), .done(done), .result(result));
   ahl_device_model #(.UNIT(1), .SCAN(20)) u_ahl_device_model (
      .core_clk(core_clk), .rst(rst), .txData(txData), .txValid(txValid),
      .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
      .delayScans(delayScans), .failCmd(failCmd), .badBcc(badBcc));
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (txtValid && txtReady) txtHead <= txtHead + 1;
      if (txValid && txReady) txQ.push_back(txData);
      if (txValid && txReady && txData == 8'h0d) crCyc <= cyc;
      if (rspValid) rspQ.push_back(rspData);
      if (done) doneCyc <= cyc;
   end
   always @(negedge core_clk) begin
      txtValid <= txtHead < txtArr.size();
      if (txtHead < txtArr.size()) txtIn <= txtArr[txtHead];
   end
   function automatic logic [7:0] hx(input logic [3:0] n);
      return n < 4'ha ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic runCmd(input logic lt, input logic sk, input logic [6:0] u,
         input int n, input int hold);
      logic [7:0] c, b;
      int t;
      expTx = {lt ? 8'h3c : 8'h25, 8'h30 + 8'(u / 10), 8'h30 + 8'(u % 10)};
      txQ.delete();
      rspQ.delete();
      expRsp.delete();
      for (int i = 0; i < n; i++) begin
         c = 8'h41 + 8'(($random(seed) & 32'hff) % 26);
         txtArr.push_back({i == n - 1, c});
         expTx.push_back(c);
      end
      // the framer stops taking text where check code and cr still fit
      while (expTx.size() > (lt ? 2045 : 115)) void'(expTx.pop_back());
      b = 8'h00;
      foreach (expTx[i]) b ^= expTx[i];
      expTx = {expTx, sk ? 8'h2a : hx(b[7:4]), sk ? 8'h2a : hx(b[3:0]), 8'h0d};
      if (er.ok || er.bccErr || er.lenErr) expRsp = {8'h24, expTx[3]};
      if (er.remoteErr) expRsp = {8'h21, 8'h34, 8'h32};
      if (er.cfgErr) expTx.delete();
      if (hold) begin
         // text queued before the start must stop at the fifo depth
         repeat (14) @(negedge core_clk);
         check(txtReady, 1'b0);
         check(txtHead == txtArr.size() - n + 8, 1'b1);
      end
      @(negedge core_clk);
      check(cmdReady, 1'b1);
      cmdStart <= 1'b1;
      cmdCfg <= {lt, sk, u};
      @(negedge core_clk);
      cmdStart <= 1'b0;
      t = 0;
      while (done !== 1'b1 && t < 6000) begin
         @(negedge core_clk);
         t++;
      end
      check(t < 6000, 1'b1);
      check(txQ.size(), expTx.size());
      foreach (expTx[i]) check(txQ[i], expTx[i]);
      check(rspQ.size(), expRsp.size());
      foreach (expRsp[i]) check(rspQ[i], expRsp[i]);
      check(result, er);
   endtask
   initial begin
      seed = 32'hcc721623;
      {errors, tests_run, cyc, txtHead, crCyc, doneCyc} = '0;
      {rst, cmdStart, failCmd, badBcc} = 4'h8;
      {cmdCfg, delayScans} = '0;
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      check({cmdReady, txValid, done, result}, 10'h200);
      er = '0;
      er.ok = 1'b1;
      for (int i = 0; i < 4; i++) runCmd(i[0], i[1], 7'd1, 1 + 2 * i, 0);
      runCmd(1'b0, 1'b0, 7'd1, 10, 1);
      delayScans = 10'd90;
      runCmd(1'b1, 1'b0, 7'd1, 3, 0);
      // doneCyc is taken one edge after the done pulse is seen
      @(negedge core_clk);
      check(doneCyc - crCyc >= 1800, 1'b1);
      delayScans = 10'd0;
      failCmd = 1'b1;
      er = '0;
      er.remoteErr = 1'b1;
      runCmd(1'b0, 1'b0, 7'd1, 2, 0);
      failCmd = 1'b0;
      badBcc = 1'b1;
      er = '0;
      er.bccErr = 1'b1;
      runCmd(1'b1, 1'b1, 7'd1, 2, 0);
      badBcc = 1'b0;
      er = '0;
      er.lenErr = 1'b1;
      runCmd(1'b0, 1'b0, 7'd1, 120, 0);
      er = '0;
      er.timeout = 1'b1;
      runCmd(1'b0, 1'b0, 7'd5, 2, 0);
      er = '0;
      er.cfgErr = 1'b1;
      runCmd(1'b0, 1'b0, 7'd0, 0, 0);
      runCmd(1'b1, 1'b0, 7'd100, 0, 0);
      conclude();
   end
   // roughly nine times the expected length of the whole run
   initial begin
      #1600000;
      errors++;
      $display("Error at %0t: watchdog expired", $time);
      conclude();
   end
endmodule
